// [shared/pcr_pkg.sv]
// Purpose: Shared constants and types for the control register upper bits block
// Assumes: Core clock of 20 MHz
// Notes: Field positions are bit indices within the 16-bit control word
`default_nettype none
package pcr_pkg;
  // Register map
  localparam logic [4:0] REG_CONTROL_ADDR = 5'h00;
  localparam logic [4:0] PHYAD_BROADCAST = 5'h00;
  // Field positions
  localparam int unsigned BIT_RESET = 15;
  localparam int unsigned BIT_LOOPBACK = 14;
  localparam int unsigned BIT_SPEED_LSB = 13;
  localparam int unsigned BIT_AN_ENABLE = 12;
  localparam int unsigned BIT_POWER_DOWN = 11;
  localparam int unsigned BIT_SPEED_MSB = 6;
  // Reset values
  localparam logic RST_LOOPBACK = 1'b0;
  localparam logic RST_SPEED_LSB = 1'b0;
  localparam logic RST_AN_ENABLE = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_SPEED_MSB = 1'b1;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  // Fixed read values outside the writable speed mode
  localparam logic FIXED_SPEED_LSB = 1'b0;
  localparam logic FIXED_SPEED_MSB = 1'b1;
  // Serial management frame
  localparam int unsigned MDIO_PRE_BITS = 32;
  localparam int unsigned MDIO_HDR_LAST = 12;
  localparam int unsigned MDIO_DATA_LAST = 15;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  // Receive clock source code that selects the recovered receive output clock
  localparam logic RXCLK_SRC_RECOVERED = 1'b1;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SOFT_RESET_NS = 1000;
  localparam int unsigned SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Line standard of the core
  typedef enum logic [1:0] {PCR_STD_1000X, PCR_STD_2500X, PCR_STD_SGMII} pcr_std_t;
endpackage
`default_nettype wire

// [hw/pcr_reset_timer.sv]
// Purpose: Times the self-clearing core reset started by the reset bit
// Assumes: start is a one-cycle pulse on sys_clk
// Notes: A start during a running reset is ignored
`timescale 1ns/1ps
`default_nettype none
module pcr_reset_timer #(
  parameter int unsigned CYCLES = pcr_pkg::SOFT_RESET_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy
);
  import pcr_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("pcr_reset_timer: CYCLES must be at least 1");
    end
  endgenerate

  logic [CW-1:0] cnt_q;
  logic busy_q;
  wire last = (cnt_q == ONE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q <= LOAD;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - ONE;
      busy_q <= !last;
    end
  end

  assign busy = busy_q;
endmodule // pcr_reset_timer
`default_nettype wire

// [hw/pcr_control_reg.sv]
// Purpose: Bits 15..11 and 6 of the coding sublayer control register with its serial management slave
// Assumes: All inputs synchronous to sys_clk; mdc well below sys_clk/2
// Notes: Bits 10..7 and 5..0 read as zero here; other register addresses read as zero
`timescale 1ns/1ps
`default_nettype none
module pcr_control_reg #(
  parameter int unsigned PRE_BITS = pcr_pkg::MDIO_PRE_BITS,
  parameter int unsigned RESET_CYCLES = pcr_pkg::SOFT_RESET_CYCLES,
  parameter bit HAS_AUTONEG = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial management link
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_address,
  // Configuration vector
  input wire logic cfg_valid,
  input wire logic [15:0] cfg_word,
  // Core options
  input wire pcr_pkg::pcr_std_t std_mode,
  input wire logic ten_bit_interface_mode,
  input wire logic ps_gem_mode,
  input wire logic rx_gmii_clock_source_select,
  input wire logic pma_present,
  // Control outputs
  output logic core_reset,
  output logic loopback_internal,
  output logic external_wrap,
  output logic an_enable,
  output logic transceiver_power_down,
  output logic [1:0] speed_code
);
  import pcr_pkg::*;

  localparam int unsigned OW = $clog2(PRE_BITS + 1);
  localparam logic [OW-1:0] PRE_LOAD = OW'(PRE_BITS);

  generate
    if (PRE_BITS < 1) begin : g_bad_pre
      $error("pcr_control_reg: PRE_BITS must be at least 1");
    end
    if (RESET_CYCLES < 1) begin : g_bad_rst
      $error("pcr_control_reg: RESET_CYCLES must be at least 1");
    end
  endgenerate

  typedef enum logic [1:0] {PCR_ST_IDLE, PCR_ST_HDR, PCR_ST_TA, PCR_ST_DATA} pcr_mdio_st_t;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine

  pcr_mdio_st_t st_q;
  logic mdc_prev_q;
  logic [OW-1:0] ones_q;
  logic [3:0] cnt_q;
  logic [11:0] hdr_q;
  logic [1:0] op_q;
  logic hit_q;
  logic [4:0] regad_q;
  logic [15:0] sh_q;
  logic mdio_out_q;
  logic mdio_oe_q;

  wire mdc_rise = mdc && !mdc_prev_q;
  wire [12:0] hdr_word = {hdr_q, mdio_in};
  wire [1:0] hdr_op = hdr_word[11:10];
  wire [4:0] hdr_phy = hdr_word[9:5];
  wire hdr_ok = hdr_word[12] && (hdr_op == OP_READ || hdr_op == OP_WRITE);
  wire hdr_hit = (hdr_phy == phy_address) || (hdr_phy == PHYAD_BROADCAST);
  wire hdr_done = (cnt_q == 4'(MDIO_HDR_LAST));
  wire data_done = (cnt_q == 4'(MDIO_DATA_LAST));
  wire rd_active = hit_q && (op_q == OP_READ);
  wire [15:0] wdata = {sh_q[14:0], mdio_in};
  wire [15:0] ctrl_rd;
  wire [15:0] rd_word = (regad_q == REG_CONTROL_ADDR) ? ctrl_rd : READ_ZERO;
  wire mgmt_wr = mdc_rise && (st_q == PCR_ST_DATA) && data_done && hit_q && (op_q == OP_WRITE)
                 && (regad_q == REG_CONTROL_ADDR);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= PCR_ST_IDLE;
      ones_q <= '0;
      cnt_q <= 4'h0;
      hdr_q <= 12'h000;
      op_q <= 2'b00;
      hit_q <= 1'b0;
      regad_q <= 5'h00;
      sh_q <= 16'h0000;
      mdio_out_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else if (mdc_rise) begin
      unique case (st_q)
        PCR_ST_IDLE: begin
          if (mdio_in) begin
            if (ones_q != PRE_LOAD) begin
              ones_q <= ones_q + OW'(1);
            end
          end else begin
            if (ones_q == PRE_LOAD) begin
              st_q <= PCR_ST_HDR;
            end
            ones_q <= '0;
            cnt_q <= 4'h0;
          end
        end
        PCR_ST_HDR: begin
          hdr_q <= hdr_word[11:0];
          cnt_q <= cnt_q + 4'h1;
          if (hdr_done) begin
            st_q <= hdr_ok ? PCR_ST_TA : PCR_ST_IDLE;
            op_q <= hdr_op;
            hit_q <= hdr_hit;
            regad_q <= hdr_word[4:0];
            cnt_q <= 4'h0;
          end
        end
        PCR_ST_TA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'h0) begin
            // Second turnaround bit is driven low by the slave
            mdio_oe_q <= rd_active;
            mdio_out_q <= 1'b0;
          end else begin
            st_q <= PCR_ST_DATA;
            cnt_q <= 4'h0;
            mdio_out_q <= rd_word[15];
            sh_q <= {rd_word[14:0], 1'b0};
          end
        end
        PCR_ST_DATA: begin
          cnt_q <= cnt_q + 4'h1;
          if (rd_active) begin
            mdio_out_q <= sh_q[15];
            sh_q <= {sh_q[14:0], 1'b0};
          end else begin
            sh_q <= wdata;
          end
          if (data_done) begin
            st_q <= PCR_ST_IDLE;
            mdio_oe_q <= 1'b0;
            mdio_out_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign mdio_out = mdio_out_q;
  assign mdio_oe = mdio_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and soft reset

  logic lb_q;
  logic s13_q;
  logic an_q;
  logic pd_q;
  logic s6_q;
  logic busy;

  wire wr_any = mgmt_wr || cfg_valid;
  wire [15:0] wr_word = mgmt_wr ? wdata : cfg_word;
  wire soft_start = wr_any && wr_word[BIT_RESET];
  wire spd_wr_ok = (std_mode == PCR_STD_SGMII) && ps_gem_mode;

  pcr_reset_timer #(
    .CYCLES(RESET_CYCLES)
  ) u_reset_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(soft_start),
    .busy(busy)
  );

  always_ff @(posedge sys_clk) begin
    if (rst || busy) begin
      lb_q <= RST_LOOPBACK;
      s13_q <= RST_SPEED_LSB;
      an_q <= RST_AN_ENABLE;
      pd_q <= RST_POWER_DOWN;
      s6_q <= RST_SPEED_MSB;
    end else if (wr_any && !wr_word[BIT_RESET]) begin
      lb_q <= wr_word[BIT_LOOPBACK];
      an_q <= wr_word[BIT_AN_ENABLE];
      pd_q <= pd_q || wr_word[BIT_POWER_DOWN];
      if (spd_wr_ok) begin
        s13_q <= wr_word[BIT_SPEED_LSB];
        s6_q <= wr_word[BIT_SPEED_MSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read value

  wire s13_rd = spd_wr_ok ? s13_q : FIXED_SPEED_LSB;
  wire s6_rd = spd_wr_ok ? s6_q : FIXED_SPEED_MSB;
  wire an_rd = HAS_AUTONEG && an_q;
  logic [15:0] ctrl_rd_v;

  always_comb begin
    ctrl_rd_v = READ_ZERO;
    ctrl_rd_v[BIT_RESET] = busy;
    ctrl_rd_v[BIT_LOOPBACK] = lb_q;
    ctrl_rd_v[BIT_SPEED_LSB] = s13_rd;
    ctrl_rd_v[BIT_AN_ENABLE] = an_rd;
    ctrl_rd_v[BIT_POWER_DOWN] = pd_q;
    ctrl_rd_v[BIT_SPEED_MSB] = s6_rd;
  end

  assign ctrl_rd = ctrl_rd_v;

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs

  wire rx_from_recovered = (rx_gmii_clock_source_select == RXCLK_SRC_RECOVERED);
  logic core_reset_q;
  logic lb_int_q;
  logic wrap_q;
  logic an_en_q;
  logic pd_out_q;
  logic [1:0] speed_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_reset_q <= 1'b0;
      lb_int_q <= RST_LOOPBACK;
      wrap_q <= RST_LOOPBACK;
      an_en_q <= 1'b0;
      pd_out_q <= RST_POWER_DOWN;
      speed_q <= {FIXED_SPEED_MSB, FIXED_SPEED_LSB};
    end else begin
      core_reset_q <= busy;
      lb_int_q <= lb_q && !ten_bit_interface_mode && !rx_from_recovered;
      wrap_q <= lb_q && ten_bit_interface_mode;
      an_en_q <= an_rd;
      pd_out_q <= pd_q && pma_present && !ten_bit_interface_mode;
      speed_q <= {s6_rd, s13_rd};
    end
  end

  assign core_reset = core_reset_q;
  assign loopback_internal = lb_int_q;
  assign external_wrap = wrap_q;
  assign an_enable = an_en_q;
  assign transceiver_power_down = pd_out_q;
  assign speed_code = speed_q;
endmodule // pcr_control_reg
`default_nettype wire

// [tb/pcr_control_reg_properties.sv]
// Purpose: Port-level assertions for the control register block
// Assumes: Bound to pcr_control_reg; output flops lag their causes by one sys_clk
// Notes: Hard reset disables every check
`timescale 1ns/1ps
`default_nettype none
module pcr_control_reg_chk #(
  parameter int unsigned RESET_CYCLES = 20,
  parameter bit HAS_AUTONEG = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire pcr_pkg::pcr_std_t std_mode,
  input wire logic ten_bit_interface_mode,
  input wire logic ps_gem_mode,
  input wire logic rx_gmii_clock_source_select,
  input wire logic pma_present,
  input wire logic core_reset,
  input wire logic loopback_internal,
  input wire logic external_wrap,
  input wire logic an_enable,
  input wire logic transceiver_power_down,
  input wire logic [1:0] speed_code
);
  import pcr_pkg::*;
  int unsigned run_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Length of the current core reset pulse
  always_ff @(posedge sys_clk) begin
    if (rst || !core_reset)
      run_q <= 0;
    else
      run_q <= run_q + 1;
  end
  a_loop_gated: assert property (loopback_internal |-> !$past(ten_bit_interface_mode)
    && !$past(rx_gmii_clock_source_select)) else $error("internal loopback while gated");
  a_wrap_tbi: assert property (external_wrap |-> $past(ten_bit_interface_mode)) else $error("wrap outside tbi");
  a_pd_gated: assert property (transceiver_power_down |-> $past(pma_present)
    && !$past(ten_bit_interface_mode)) else $error("power down while gated");
  a_pd_sticky: assert property ($fell(transceiver_power_down) |-> core_reset
    || $past(ten_bit_interface_mode) || !$past(pma_present)) else $error("power down cleared by write");
  a_speed_fixed: assert property ($past(std_mode) != PCR_STD_SGMII || !$past(ps_gem_mode)
    |-> speed_code == 2'b10) else $error("speed not fixed");
  a_an_default: assert property ($fell(rst) |=> an_enable == HAS_AUTONEG) else $error("autoneg default");
  a_reset_len: assert property ($fell(core_reset) |-> run_q == RESET_CYCLES) else $error("reset length");
  a_reset_clears: assert property ($rose(core_reset) |=> !loopback_internal && !external_wrap
    && !transceiver_power_down && an_enable == HAS_AUTONEG) else $error("defaults not restored");
  a_read_window: assert property ($rose(mdio_oe) |-> !mdio_out ##0 mdio_oe [*8] ##[1:1000] !mdio_oe)
    else $error("read drive window");
endmodule // pcr_control_reg_chk
bind pcr_control_reg pcr_control_reg_chk #(.RESET_CYCLES(RESET_CYCLES), .HAS_AUTONEG(HAS_AUTONEG)) chk_inst (
  .sys_clk(sys_clk), .rst(rst), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .std_mode(std_mode),
  .ten_bit_interface_mode(ten_bit_interface_mode), .ps_gem_mode(ps_gem_mode), .pma_present(pma_present),
  .rx_gmii_clock_source_select(rx_gmii_clock_source_select), .core_reset(core_reset),
  .loopback_internal(loopback_internal), .external_wrap(external_wrap), .an_enable(an_enable),
  .transceiver_power_down(transceiver_power_down), .speed_code(speed_code));
`default_nettype wire

// [tb/pcr_mdio_master.sv]
// Purpose: Station management master model
// Assumes: mdc is a quarter of sys_clk and stands low outside frames
// Notes: Releases the data line during read turnaround and data
`timescale 1ns/1ps
`default_nettype none
module pcr_mdio_master #(
  parameter int unsigned PRE_BITS = 4
) (
  // Clock
  input wire logic sys_clk,
  // Management link
  output logic mdc,
  output logic m_out,
  output logic m_oe,
  input wire logic mdio_wire
);
  logic s;
  initial begin
    mdc = 1'b0;
    m_out = 1'b0;
    m_oe = 1'b0;
  end
  // One bit: change while mdc is low, sample just before the rise
  task automatic tick(input logic drv, input logic b);
    @(posedge sys_clk);
    mdc <= 1'b0;
    m_oe <= drv;
    m_out <= b;
    repeat (2) @(posedge sys_clk);
    s = mdio_wire;
    mdc <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    hdr = {2'b01, op, phy, ra};
    rd = 16'h0000;
    repeat (PRE_BITS) tick(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) tick(1'b1, hdr[i]);
    tick(op == 2'b01, 1'b1);
    tick(op == 2'b01, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      tick(op == 2'b01, wd[i]);
      rd[i] = s;
    end
    @(posedge sys_clk);
    mdc <= 1'b0;
    m_oe <= 1'b0;
  endtask
endmodule // pcr_mdio_master
`default_nettype wire

// [tb/pcr_control_reg_tb.sv]
// Purpose: Self-checking bench for the control register upper bits
// Assumes: Shortened preamble; soft reset lengthened to 200 cycles
// Notes: Data wire has a pull-up when nobody drives it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module pcr_control_reg_tb;
  import pcr_pkg::*;
  localparam int unsigned RC = 200;
  logic sys_clk, rst, mdc, mdio_out, mdio_oe, m_out, m_oe, mdio_wire, cfg_valid;
  logic ten, gem, rxsrc, pma, core_reset, lb, wrap, an, pd;
  logic [4:0] phy_address;
  logic [15:0] cfg_word, rdv;
  logic [1:0] speed_code;
  pcr_std_t std_mode;
  int error_cnt = 0;
  int checks = 0;
  assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
  pcr_control_reg #(.PRE_BITS(4), .RESET_CYCLES(RC), .HAS_AUTONEG(1'b1)) pcr_control_reg_inst (
    .sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .phy_address(phy_address), .cfg_valid(cfg_valid), .cfg_word(cfg_word), .std_mode(std_mode),
    .ten_bit_interface_mode(ten), .ps_gem_mode(gem), .rx_gmii_clock_source_select(rxsrc), .pma_present(pma),
    .core_reset(core_reset), .loopback_internal(lb), .external_wrap(wrap), .an_enable(an),
    .transceiver_power_down(pd), .speed_code(speed_code));
  pcr_mdio_master #(.PRE_BITS(4)) pcr_mdio_master_inst (
    .sys_clk(sys_clk), .mdc(mdc), .m_out(m_out), .m_oe(m_oe), .mdio_wire(mdio_wire));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    logic [15:0] x;
    pcr_mdio_master_inst.xfer(OP_WRITE, 5'h03, 5'h00, d, x);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] e);
    pcr_mdio_master_inst.xfer(OP_READ, phy, ra, 16'h0000, rdv);
    `CHK(rdv, e)
  endtask
  task automatic cfg(input logic [15:0] w);
    @(posedge sys_clk);
    cfg_valid <= 1'b1;
    cfg_word <= w;
    @(posedge sys_clk);
    cfg_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic setm(input pcr_std_t s, input logic t, input logic g, input logic x);
    @(posedge sys_clk);
    std_mode <= s;
    ten <= t;
    gem <= g;
    rxsrc <= x;
    repeat (3) @(posedge sys_clk);
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rst, pma} = 2'b11;
    {cfg_valid, ten, gem, rxsrc} = 4'h0;
    cfg_word = 16'h0000;
    std_mode = PCR_STD_1000X;
    phy_address = 5'h03;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(5'h03, 5'h00, 16'h1040);
    `CHK({an, speed_code}, 3'b110)
    rd(5'h00, 5'h00, 16'h1040);
    rd(5'h03, 5'h01, 16'h0000);
    rd(5'h07, 5'h00, 16'hFFFF);
    wr(16'h4000);
    `CHK({lb, wrap, an}, 3'b100)
    rd(5'h03, 5'h00, 16'h4040);
    setm(PCR_STD_1000X, 1'b0, 1'b0, 1'b1);
    `CHK(lb, 1'b0)
    setm(PCR_STD_1000X, 1'b1, 1'b0, 1'b0);
    `CHK({lb, wrap}, 2'b01)
    setm(PCR_STD_1000X, 1'b0, 1'b0, 1'b0);
    cfg(16'h1800);
    `CHK({pd, an, lb}, 3'b110)
    cfg(16'h1000);
    `CHK(pd, 1'b1)
    setm(PCR_STD_1000X, 1'b1, 1'b0, 1'b0);
    `CHK(pd, 1'b0)
    setm(PCR_STD_1000X, 1'b0, 1'b0, 1'b0);
    `CHK(pd, 1'b1)
    pma <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(pd, 1'b0)
    pma <= 1'b1;
    wr(16'h8000);
    `CHK(core_reset, 1'b1)
    rd(5'h03, 5'h00, 16'h9040);
    repeat (RC) @(posedge sys_clk);
    rd(5'h03, 5'h00, 16'h1040);
    `CHK({pd, core_reset}, 2'b00)
    setm(PCR_STD_SGMII, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr({2'b00, i[0], 6'h00, i[1], 6'h00});
      `CHK(speed_code, i[1:0])
    end
    setm(PCR_STD_SGMII, 1'b0, 1'b0, 1'b0);
    rd(5'h03, 5'h00, 16'h0040);
    setm(PCR_STD_2500X, 1'b0, 1'b1, 1'b0);
    rd(5'h03, 5'h00, 16'h0040);
    report_and_stop();
  end
endmodule // pcr_control_reg_tb
`undef CHK
`default_nettype wire
